// File: core/iotlb_completion_granularity.sv
// register-driven iotlb invalidation with actual granularity report
// assumes a single-cycle register master synchronous to clk
`timescale 1ns/100ps
`include "iotlb_gran_defines.svh"
module iotlb_completion_granularity
    import iotlb_gran_pkg::*;
#(
    parameter int WORK_CYCLES   = 4,
    parameter int MAX_ADDR_MASK = 9
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire iotlb_gran_pkg::reg_req_t bus,
    output logic [63:0]           rdata,
    output logic                  irq,
    output logic                  inv_busy,
    output logic [1:0]            inv_scope,
    output logic [15:0]           inv_domain
);
    import iotlb_gran_pkg::*;

    initial begin
        if (WORK_CYCLES < 1 || WORK_CYCLES > 255) begin
            $error("WORK_CYCLES out of range");
        end
        if (MAX_ADDR_MASK < 0 || MAX_ADDR_MASK > 63) begin
            $error("MAX_ADDR_MASK out of range");
        end
    end

    localparam logic [7:0] WORK_LAST = 8'(WORK_CYCLES - 1);
    localparam logic [5:0] MASK_MAX  = 6'(MAX_ADDR_MASK);

    inv_core_t core_reg;
    inv_core_t core_next;

    logic       incorrect;
    logic [1:0] applied;
    logic       req_start;
    logic [1:0] events;

    // judge the latched request
    always_comb begin
        incorrect = 1'b0;
        if (core_reg.table_mode_select != `TTM_LEGACY) begin
            incorrect = 1'b1;
        end
        if (core_reg.major_ver >= `MAJOR_VER_QI_ONLY) begin
            incorrect = 1'b1;
        end
        if (core_reg.req_gran == `GRAN_ERROR) begin
            incorrect = 1'b1;
        end
        if (core_reg.req_gran == `GRAN_PAGE &&
            core_reg.inv_addr[`ADDR_MASK_HI:0] > MASK_MAX) begin
            incorrect = 1'b1;
        end
        unique case (core_reg.req_gran)
            `GRAN_GLOBAL: applied = `GRAN_GLOBAL;
            `GRAN_DOMAIN: applied = `GRAN_DOMAIN;
            `GRAN_PAGE:   applied = `GRAN_PAGE;
            default:      applied = `GRAN_ERROR;
        endcase
        if (incorrect) begin
            applied = `GRAN_ERROR;
        end
    end

    assign req_start = bus.wr && bus.addr == `ADDR_INV_REQ &&
                       bus.wdata[`REQ_FLAG_BIT] && !core_reg.flag;

    always_comb begin
        core_next = core_reg;
        events    = 2'h0;
        core_next.rdata = `RESET_WORD;
        if (bus.wr) begin
            unique case (bus.addr)
                `ADDR_INV_REQ: begin
                    if (req_start) begin
                        core_next.flag     = 1'b1;
                        core_next.req_gran =
                            bus.wdata[`REQ_GRAN_HI:`REQ_GRAN_LO];
                        core_next.domain   = bus.wdata[`REQ_DID_LO +: 16];
                    end
                end
                `ADDR_INV_ADDR: begin
                    if (!core_reg.flag) begin
                        core_next.inv_addr = bus.wdata;
                    end
                end
                `ADDR_IRQ_ENABLE: core_next.irq_en = bus.wdata[1:0];
                `ADDR_CONFIG: begin
                    core_next.table_mode_select       = bus.wdata[`CFG_TTM_LO +: 2];
                    core_next.major_ver = bus.wdata[`CFG_VER_LO +: 4];
                end
                default: ;
            endcase
        end
        unique case (core_reg.state)
            ST_IDLE: begin
                if (req_start) begin
                    core_next.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                core_next.plan_gran = applied;
                core_next.work_cnt  = 8'h0;
                core_next.state     = ST_WORK;
            end
            ST_WORK: begin
                if (core_reg.plan_gran == `GRAN_ERROR ||
                    core_reg.work_cnt == WORK_LAST) begin
                    core_next.flag     = 1'b0;
                    core_next.act_gran = core_reg.plan_gran;
                    core_next.state    = ST_IDLE;
                    events[0] = 1'b1;
                    events[1] = core_reg.plan_gran == `GRAN_ERROR;
                end else begin
                    core_next.work_cnt = core_reg.work_cnt + 8'h1;
                end
            end
        endcase
        // clear then set, so a same-cycle event survives
        if (bus.wr && bus.addr == `ADDR_IRQ_CLEAR) begin
            core_next.status = core_reg.status & ~bus.wdata[1:0];
        end
        core_next.status = core_next.status | events;
        if (bus.rd) begin
            unique case (bus.addr)
                `ADDR_INV_REQ: begin
                    core_next.rdata[`REQ_FLAG_BIT] = core_reg.flag;
                    core_next.rdata[`REQ_GRAN_HI:`REQ_GRAN_LO] =
                        core_reg.req_gran;
                    core_next.rdata[`REQ_ACT_HI:`REQ_ACT_LO] =
                        core_reg.act_gran;
                    core_next.rdata[`REQ_DID_LO +: 16] = core_reg.domain;
                end
                `ADDR_INV_ADDR:   core_next.rdata = core_reg.inv_addr;
                `ADDR_STATUS:     core_next.rdata[1:0] = core_reg.status;
                `ADDR_IRQ_ENABLE: core_next.rdata[1:0] = core_reg.irq_en;
                `ADDR_CONFIG: begin
                    core_next.rdata[`CFG_TTM_LO +: 2] = core_reg.table_mode_select;
                    core_next.rdata[`CFG_VER_LO +: 4] = core_reg.major_ver;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_reg       <= '0;
            core_reg.state <= ST_IDLE;
        end else begin
            core_reg <= core_next;
        end
    end

    assign rdata      = core_reg.rdata;
    assign irq        = |(core_reg.status & core_reg.irq_en);
    assign inv_busy   = core_reg.state == ST_WORK &&
                        core_reg.plan_gran != `GRAN_ERROR;
    assign inv_scope  = core_reg.plan_gran;
    assign inv_domain = core_reg.domain;

    property p_act_on_clear;
        @(posedge clk) disable iff (!arst_n)
        $fell(core_reg.flag) |-> core_reg.act_gran == $past(core_reg.plan_gran);
    endproperty
    a_act_on_clear: assert property (p_act_on_clear)
        else $error("actual granularity not updated at completion");

    property p_err_no_work;
        @(posedge clk) disable iff (!arst_n)
        core_reg.state == ST_WORK && core_reg.plan_gran == `GRAN_ERROR
            |-> !inv_busy ##1 !core_reg.flag;
    endproperty
    a_err_no_work: assert property (p_err_no_work)
        else $error("incorrect request performed work");

    property p_ttm_err;
        @(posedge clk) disable iff (!arst_n)
        core_reg.state == ST_CHECK && core_reg.table_mode_select != `TTM_LEGACY
            |=> core_reg.plan_gran == `GRAN_ERROR;
    endproperty
    a_ttm_err: assert property (p_ttm_err)
        else $error("non-legacy table mode not rejected");

    property p_mask_err;
        @(posedge clk) disable iff (!arst_n)
        core_reg.state == ST_CHECK && core_reg.req_gran == `GRAN_PAGE &&
        core_reg.inv_addr[`ADDR_MASK_HI:0] > MASK_MAX
            |=> core_reg.plan_gran == `GRAN_ERROR;
    endproperty
    a_mask_err: assert property (p_mask_err)
        else $error("unsupported mask not rejected");

    property p_ver_err;
        @(posedge clk) disable iff (!arst_n)
        core_reg.state == ST_CHECK &&
        core_reg.major_ver >= `MAJOR_VER_QI_ONLY
            |=> core_reg.plan_gran == `GRAN_ERROR;
    endproperty
    a_ver_err: assert property (p_ver_err)
        else $error("new version register request not rejected");

    property p_global;
        @(posedge clk) disable iff (!arst_n)
        core_reg.state == ST_CHECK && !incorrect &&
        core_reg.req_gran == `GRAN_GLOBAL
            |=> core_reg.plan_gran == `GRAN_GLOBAL;
    endproperty
    a_global: assert property (p_global)
        else $error("global request misreported");

    property p_domain;
        @(posedge clk) disable iff (!arst_n)
        core_reg.state == ST_CHECK && !incorrect &&
        core_reg.req_gran == `GRAN_DOMAIN
            |=> core_reg.plan_gran == `GRAN_DOMAIN;
    endproperty
    a_domain: assert property (p_domain)
        else $error("domain request misreported");

    property p_page_only;
        @(posedge clk) disable iff (!arst_n)
        $fell(core_reg.flag) && core_reg.act_gran == `GRAN_PAGE
            |-> core_reg.req_gran == `GRAN_PAGE;
    endproperty
    a_page_only: assert property (p_page_only)
        else $error("page report without page request");

    property p_complete;
        @(posedge clk) disable iff (!arst_n)
        $rose(core_reg.flag) |-> ##[2:258] !core_reg.flag;
    endproperty
    a_complete: assert property (p_complete)
        else $error("request flag not cleared in time");

    property p_stable;
        @(posedge clk) disable iff (!arst_n)
        !$fell(core_reg.flag) |-> $stable(core_reg.act_gran);
    endproperty
    a_stable: assert property (p_stable)
        else $error("actual granularity changed outside completion");
endmodule

// File: core/iotlb_gran_defines.svh
// constants for the invalidation completion block
// assumes inclusion by the core module
`ifndef IOTLB_GRAN_DEFINES_SVH
`define IOTLB_GRAN_DEFINES_SVH
`define GRAN_ERROR        2'h0
`define GRAN_GLOBAL       2'h1
`define GRAN_DOMAIN       2'h2
`define GRAN_PAGE         2'h3
`define TTM_LEGACY        2'h0
`define MAJOR_VER_QI_ONLY 4'h6
`define ADDR_INV_REQ      4'h0
`define ADDR_INV_ADDR     4'h1
`define ADDR_STATUS       4'h2
`define ADDR_IRQ_CLEAR    4'h3
`define ADDR_IRQ_ENABLE   4'h4
`define ADDR_CONFIG       4'h5
`define REQ_FLAG_BIT      63
`define REQ_GRAN_HI       61
`define REQ_GRAN_LO       60
`define REQ_ACT_HI        58
`define REQ_ACT_LO        57
`define REQ_DID_LO        0
`define ADDR_MASK_HI      5
`define CFG_TTM_LO        0
`define CFG_VER_LO        4
`define RESET_WORD        64'h0
`endif

// File: core/iotlb_gran_pkg.sv
// types for the invalidation completion block
// assumes the defines header sits beside it
package iotlb_gran_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_WORK  = 3'b100
    } inv_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [63:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        inv_state_t  state;
        logic        flag;
        logic [1:0]  req_gran;
        logic [1:0]  act_gran;
        logic [15:0] domain;
        logic [63:0] inv_addr;
        logic [1:0]  table_mode_select;
        logic [3:0]  major_ver;
        logic [1:0]  status;
        logic [1:0]  irq_en;
        logic [1:0]  plan_gran;
        logic [7:0]  work_cnt;
        logic [63:0] rdata;
    } inv_core_t;
endpackage

// File: verif/iotlb_completion_granularity_tb_top.sv
// self-checking bench for the invalidation completion block
// assumes the core package and the defines header on the include path
`timescale 1ns/100ps
module iotlb_completion_granularity_tb_top;
    import iotlb_gran_pkg::*;
    logic        clk;
    logic        arst_n;
    reg_req_t    bus;
    logic [63:0] rdata;
    logic        irq;
    logic        inv_busy;
    logic [1:0]  inv_scope;
    logic [15:0] inv_domain;
    int          err_total;
    int          checks;
    int          cyc;
    logic        busy_seen;
    logic [1:0]  busy_scope;
    logic [31:0] seed;
    logic [13:0] corner [10];
    logic [13:0] c;

    iotlb_completion_granularity i_iotlb_completion_granularity (
        .clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .irq(irq),
        .inv_busy(inv_busy), .inv_scope(inv_scope),
        .inv_domain(inv_domain));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (inv_busy) begin
            busy_seen <= 1'b1;
            busy_scope <= inv_scope;
        end
        if (cyc == 5000) begin
            err_total = err_total + 1;
            give_verdict();
        end
    end

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // c = {requested, table mode, major version, address mask}
    function automatic logic [1:0] exp_gran(input logic [13:0] k);
        if (k[13:12] == 2'h0 || k[11:10] != 2'h0 || k[9:6] >= 4'h6)
            return 2'h0;
        if (k[13:12] == 2'h3 && k[5:0] > 6'h09)
            return 2'h0;
        return k[13:12];
    endfunction

    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [63:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [63:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 64'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdata;
    endtask

    task automatic run(input logic [13:0] k);
        logic [63:0] v;
        logic [1:0]  e;
        logic [1:0]  en;
        logic [1:0]  st;
        logic [15:0] domain_identifier_field;
        int          n;
        e = exp_gran(k);
        st = {e == 2'h0, 1'b1};
        en = seed[1:0];
        domain_identifier_field = seed[31:16];
        wr(4'h5, {56'h0, k[9:6], 2'h0, k[11:10]});
        wr(4'h1, {seed, seed[31:6], k[5:0]});
        wr(4'h4, {62'h0, en});
        busy_seen = 1'b0;
        wr(4'h0, {2'h2, k[13:12], 44'h0, domain_identifier_field});
        if (e != 2'h0)
            wr(4'h0, {2'h2, ~k[13:12], 44'h0, ~domain_identifier_field});
        n = 0;
        do begin
            rd(4'h0, v);
            n++;
        end while (v[63] && n < 100);
        chk("flag", v[63], 64'h0);
        chk("actual", v[58:57], e);
        chk("requested", v[61:60], k[13:12]);
        chk("domain", v[15:0], domain_identifier_field);
        chk("worked", busy_seen, e != 2'h0);
        if (e != 2'h0)
            chk("scope", busy_scope, e);
        rd(4'h2, v);
        chk("status", v, {62'h0, st});
        chk("irq", irq, |(st & en));
        wr(4'h3, 64'h3);
        rd(4'h0, v);
        chk("held", v[58:57], e);
        chk("irq clear", irq, 64'h0);
        seed = nxt(seed);
    endtask

    initial begin
        logic [63:0] v;
        arst_n = 1'b0;
        bus = '0;
        seed = 32'h7A57C2B5;
        err_total = 0;
        checks = 0;
        cyc = 0;
        busy_seen = 1'b0;
        busy_scope = 2'h0;
        // version 6 and above: queued path expected of software
        corner = '{14'h1000, 14'h2000, 14'h3009, 14'h300A, 14'h0000,
                   14'h1400, 14'h2C00, 14'h1180, 14'h3140, 14'h23C0};
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1 chk("reset", {rdata, irq, inv_busy, inv_scope, inv_domain}, 0);
        rd(4'h0, v);
        chk("req reset", v, 64'h0);
        wr(4'hA, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(4'hA, v);
        chk("unmapped", v, 64'h0);
        foreach (corner[i])
            run(corner[i]);
        repeat (20) begin
            c = {seed[3:2], seed[4] ? seed[6:5] : 2'h0,
                 seed[7] ? seed[11:8] : {1'b0, seed[10:8]},
                 seed[18] ? seed[17:12] : {2'h0, seed[15:12]}};
            run(c);
        end
        give_verdict();
    end
endmodule
